// file: tif_pkg.sv
/*
 * Package of the fill, transmit-start and status interrupt block:
 * register offsets, field positions, reset values and mode codes.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package tif_pkg;
    // Printed offsets are not word multiples: byte address = 4 * index
    localparam logic [7:0] TIF_IDX_OVR    = 8'h0d;
    localparam logic [7:0] TIF_IDX_STAT   = 8'h0e;
    localparam logic [7:0] TIF_IDX_THR    = 8'h0f;
    localparam logic [7:0] TIF_IDX_CTRL   = 8'h20;
    localparam logic [7:0] TIF_IDX_IRQST  = 8'h21;
    localparam logic [7:0] TIF_IDX_IRQMSK = 8'h22;
    localparam logic [7:0] TIF_IDX_LEVEL  = 8'h23;
    localparam int TIF_B_FILL_METHOD = 7;
    localparam int TIF_B_FILL        = 6;
    localparam int TIF_B_TXDONE      = 5;
    localparam int TIF_B_TXSTART     = 4;
    localparam int TIF_B_RES         = 3;
    localparam int TIF_B_SIGLVL      = 2;
    localparam int TIF_B_LOCK        = 1;
    localparam int TIF_B_LOCK_EN     = 0;
    localparam logic [7:0] TIF_STAT_RST   = 8'h01;
    localparam logic [7:0] TIF_THR_RST    = 8'h00;
    localparam logic [1:0] TIF_CTRL_RST   = 2'h0;
    localparam logic [3:0] TIF_MSK_RST    = 4'h0;
    // Sticky event bits of the interrupt status register
    localparam int TIF_E_TXDONE = 0;
    localparam int TIF_E_SIGLVL = 1;
    localparam int TIF_E_OVR    = 2;
    localparam int TIF_E_SYNC   = 3;
    localparam int TIF_NEV      = 4;
    localparam logic [1:0] TIF_MODE_CONT = 2'h0;
    localparam logic [1:0] TIF_MODE_BUF  = 2'h1;
    typedef enum logic [2:0] {
        TIF_F_IDLE = 3'h1,
        TIF_F_WAIT = 3'h2,
        TIF_F_FILL = 3'h4
    } tif_fill_t;
endpackage

// file: tif_flag.sv
/*
 * One sticky flag: hardware set, write-one clear, set wins.
 * Assumes the set and clear are synchronous one-clock qualifiers.
 */
`timescale 1ns/1ps
module tif_flag
    import tif_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_ff
);
    wire nxt_flag = set_in | (flag_ff & ~clr_in);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
        set_in |=> flag_ff) else $error("flag set lost");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        flag_ff && !clr_in |=> flag_ff) else $error("flag dropped");
endmodule // tif_flag

// file: tif_start.sv
/*
 * Transmit start and interrupt output 0 selection by data mode.
 * Assumes FIFO indications arrive synchronous to sys_clk.
 */
`timescale 1ns/1ps
module tif_start
    import tif_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [1:0] data_mode,
    input  wire logic       tx_start_sel,
    input  wire logic       fifo_full,
    input  wire logic       fifo_not_empty,
    input  wire logic       fill_level_hit,
    output logic            tx_start_ff,
    output logic            irq0_ff
);
    wire is_buf = (data_mode == TIF_MODE_BUF);
    wire is_pkt = data_mode[1];
    wire buf_go = tx_start_sel ? fifo_not_empty : fifo_full;
    wire pkt_go = tx_start_sel ? fifo_not_empty : fill_level_hit;
    wire nxt_tx_start = (is_buf & buf_go) | (is_pkt & pkt_go);
    wire nxt_irq0 = (is_pkt & ~tx_start_sel) ? fill_level_hit
                  : (is_buf | is_pkt) & fifo_not_empty;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_start_ff <= 1'b0;
            irq0_ff     <= 1'b0;
        end
        else
        begin
            tx_start_ff <= nxt_tx_start; // [RQ7] [RQ8] [RQ9] [RQ10]
            irq0_ff     <= nxt_irq0;     // [RQ7] [RQ10] [RQ17]
        end
    end

    AST_BUF_FULL: assert property (@(posedge sys_clk) disable iff (rst)
        is_buf && !tx_start_sel && !fifo_full |=> !tx_start_ff) // [RQ7]
        else $error("buffered start without full FIFO");
    AST_BUF_ANY: assert property (@(posedge sys_clk) disable iff (rst)
        is_buf && tx_start_sel && fifo_not_empty |=> tx_start_ff) // [RQ8]
        else $error("buffered start missing");
    AST_PKT_THR: assert property (@(posedge sys_clk) disable iff (rst)
        is_pkt && !tx_start_sel |=> tx_start_ff == $past(fill_level_hit)
        && irq0_ff == $past(fill_level_hit)) // [RQ9]
        else $error("packet threshold start wrong");
    AST_PKT_NE: assert property (@(posedge sys_clk) disable iff (rst)
        is_pkt && tx_start_sel |=> irq0_ff == $past(fifo_not_empty)) // [RQ10]
        else $error("packet irq0 wrong");
    AST_CONT: assert property (@(posedge sys_clk) disable iff (rst)
        data_mode == TIF_MODE_CONT |=> !tx_start_ff) // [RQ17]
        else $error("start in continuous mode");
    COV_PKT_START: cover property (@(posedge sys_clk)
        is_pkt && !tx_start_sel && fill_level_hit);
endmodule // tif_start

// file: tif_top.sv
/*
 * Fill control, transmit-start selection, transmit-done, signal level
 * and lock status with a Wishbone slave and a masked interrupt.
 * Assumes all inputs synchronous to sys_clk; one-cycle event pulses.
 */
// Operation
// [RQ1] Buffered default: sync word starts FIFO fill
// [RQ2] Fill method 1: software controls filling
// [RQ3] Auto fill: fill bit high while loading
// [RQ4] Auto: write one clears, rearms if no overrun
// [RQ5] Manual: write 1 starts, 0 stops fill
// [RQ6] Transmit-done flag set after last bit
// [RQ7] Buffered sel 0: start on full, irq0 nonempty
// [RQ8] Buffered sel 1: start on nonempty
// [RQ9] Packet sel 0: start at threshold, irq0 threshold
// [RQ10] Packet sel 1: start and irq0 on nonempty
// [RQ11] Signal level above threshold sets flag, W1C
// [RQ12] Lock flag shows lock, write one clears
// [RQ13] Bit 0 enables lock detect pin, default 1
// [RQ14] Threshold register, eight bits, reset zero
// [RQ15] Host writes reserved bit 3 as one
// [RQ16] Overrun flag, write one clears flag, FIFO
// [RQ17] Mode field: continuous, buffered, packet
// [RQ18] Sticky flags hold until written one; the transmit-done flag is never cleared by a write
`timescale 1ns/1ps
module tif_top
    import tif_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [1:0]  data_mode,
    input  wire logic        sync_detect,
    input  wire logic        overrun_event,
    input  wire logic        tx_last_bit_out,
    input  wire logic [7:0]  signal_level,
    input  wire logic        synth_locked,
    input  wire logic        fifo_full,
    input  wire logic        fifo_not_empty,
    input  wire logic        fill_level_hit,
    output logic             fifo_fill_en_ff,
    output logic             fifo_flush_ff,
    output logic             tx_start_ff,
    output logic             irq0_ff,
    output logic             lock_pin_ff,
    output logic             irq_ff
);
    logic       fill_method_ff;
    logic       tx_start_sel_ff;
    logic       res_bit_ff;
    logic       lock_en_ff;
    logic [7:0] thr_ff;
    logic [3:0] irq_mask_ff;
    tif_fill_t  fill_st_ff;
    tif_fill_t  nxt_fill_st;
    logic       txdone_f;
    logic       siglvl_f;
    logic       lock_f;
    logic       ovr_f;
    logic [TIF_NEV-1:0] ev_f;

    // Bus decode
    wire        req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire [7:0]  idx    = wb_adr_i[9:2];
    wire        hi_ok  = (wb_adr_i[31:10] == 22'h0);
    wire        sel_ovr  = hi_ok & (idx == TIF_IDX_OVR);
    wire        sel_stat = hi_ok & (idx == TIF_IDX_STAT);
    wire        sel_thr  = hi_ok & (idx == TIF_IDX_THR);
    wire        sel_ctrl = hi_ok & (idx == TIF_IDX_CTRL);
    wire        sel_ist  = hi_ok & (idx == TIF_IDX_IRQST);
    wire        sel_msk  = hi_ok & (idx == TIF_IDX_IRQMSK);
    wire        sel_lvl  = hi_ok & (idx == TIF_IDX_LEVEL);
    wire        mapped = sel_ovr | sel_stat | sel_thr | sel_ctrl
                       | sel_ist | sel_msk | sel_lvl;
    wire        wr0    = req & wb_we_i & wb_sel_i[0];
    wire [7:0]  wd     = wb_dat_i[7:0];
    wire        wr_stat = wr0 & sel_stat;

    // Fill state machine
    wire fill_bit = (fill_st_ff == TIF_F_FILL);
    wire in_buf   = (data_mode == TIF_MODE_BUF);
    wire w_fill   = wr_stat & wd[TIF_B_FILL];
    wire w_method = wr_stat ? wd[TIF_B_FILL_METHOD] : fill_method_ff;

    always_comb
    begin
        nxt_fill_st = fill_st_ff;
        unique case (fill_st_ff)
            TIF_F_IDLE:
                if (w_method)
                    nxt_fill_st = w_fill ? TIF_F_FILL : TIF_F_IDLE; // [RQ5]
                else if (!ovr_f)
                    nxt_fill_st = TIF_F_WAIT;
            TIF_F_WAIT:
                if (w_method)
                    nxt_fill_st = w_fill ? TIF_F_FILL : TIF_F_IDLE; // [RQ2]
                else if (sync_detect && in_buf)
                    nxt_fill_st = TIF_F_FILL;                     // [RQ1]
            TIF_F_FILL:
                if (w_method)
                begin
                    if (wr_stat && !wd[TIF_B_FILL])
                        nxt_fill_st = TIF_F_IDLE;                 // [RQ5]
                end
                else if (w_fill)
                    nxt_fill_st = ovr_f ? TIF_F_IDLE : TIF_F_WAIT; // [RQ4]
            default:
                nxt_fill_st = TIF_F_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fill_st_ff <= TIF_F_IDLE;
        else
            fill_st_ff <= nxt_fill_st;
    end

    // Control registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fill_method_ff  <= TIF_STAT_RST[TIF_B_FILL_METHOD];
            tx_start_sel_ff <= TIF_STAT_RST[TIF_B_TXSTART];
            res_bit_ff      <= TIF_STAT_RST[TIF_B_RES];
            lock_en_ff      <= TIF_STAT_RST[TIF_B_LOCK_EN];
            thr_ff          <= TIF_THR_RST;
            irq_mask_ff     <= TIF_MSK_RST;
        end
        else
        begin
            if (wr_stat)
            begin
                fill_method_ff  <= wd[TIF_B_FILL_METHOD];
                tx_start_sel_ff <= wd[TIF_B_TXSTART];
                res_bit_ff      <= wd[TIF_B_RES];
                lock_en_ff      <= wd[TIF_B_LOCK_EN]; // [RQ13]
            end
            if (wr0 && sel_thr)
                thr_ff <= wd;                         // [RQ14]
            if (wr0 && sel_msk)
                irq_mask_ff <= wd[TIF_NEV-1:0];
        end
    end

    // Sticky flags
    wire siglvl_hit = (signal_level > thr_ff);
    wire ovr_clr    = wr0 & sel_ovr & wd[0];

    tif_flag u_txdone (
        .sys_clk (sys_clk),
        .rst     (rst),
        .set_in  (tx_last_bit_out),                      // [RQ6]
        .clr_in  (1'b0),
        .flag_ff (txdone_f)
    );
    tif_flag u_siglvl (
        .sys_clk (sys_clk),
        .rst     (rst),
        .set_in  (siglvl_hit),                           // [RQ11]
        .clr_in  (wr_stat & wd[TIF_B_SIGLVL]),           // [RQ18]
        .flag_ff (siglvl_f)
    );
    tif_flag u_lock (
        .sys_clk (sys_clk),
        .rst     (rst),
        .set_in  (synth_locked),                         // [RQ12]
        .clr_in  (wr_stat & wd[TIF_B_LOCK]),
        .flag_ff (lock_f)
    );
    tif_flag u_ovr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .set_in  (overrun_event),                        // [RQ16]
        .clr_in  (ovr_clr),
        .flag_ff (ovr_f)
    );

    wire [TIF_NEV-1:0] ev_set = {sync_detect & in_buf, overrun_event,
                                 siglvl_hit, tx_last_bit_out};
    genvar g;
    generate
        for (g = 0; g < TIF_NEV; g++)
        begin : g_ev
            tif_flag u_ev (
                .sys_clk (sys_clk),
                .rst     (rst),
                .set_in  (ev_set[g]),
                .clr_in  (wr0 & sel_ist & wd[g]),
                .flag_ff (ev_f[g])
            );
        end
    endgenerate

    tif_start u_start (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .data_mode      (data_mode),
        .tx_start_sel   (tx_start_sel_ff),
        .fifo_full      (fifo_full),
        .fifo_not_empty (fifo_not_empty),
        .fill_level_hit (fill_level_hit),
        .tx_start_ff    (tx_start_ff),
        .irq0_ff        (irq0_ff)
    );

    wire [7:0] stat_rd = {fill_method_ff, fill_bit, txdone_f,
                          tx_start_sel_ff, res_bit_ff, siglvl_f,
                          lock_f, lock_en_ff};
    wire [7:0] rd_mux =
          sel_ovr  ? {7'h0, ovr_f}
        : sel_stat ? stat_rd
        : sel_thr  ? thr_ff
        : sel_ctrl ? {6'h0, data_mode}
        : sel_ist  ? {4'h0, ev_f}
        : sel_msk  ? {4'h0, irq_mask_ff}
        : sel_lvl  ? signal_level
        : 8'h00;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wb_ack_o        <= 1'b0;
            wb_err_o        <= 1'b0;
            wb_dat_o        <= 32'h0;
            fifo_fill_en_ff <= 1'b0;
            fifo_flush_ff   <= 1'b0;
            lock_pin_ff     <= 1'b0;
            irq_ff          <= 1'b0;
        end
        else
        begin
            wb_ack_o        <= req & mapped;
            wb_err_o        <= req & ~mapped;
            wb_dat_o        <= {24'h0, rd_mux};
            fifo_fill_en_ff <= (nxt_fill_st == TIF_F_FILL); // [RQ3]
            fifo_flush_ff   <= ovr_clr;                     // [RQ16]
            lock_pin_ff     <= lock_en_ff & synth_locked;   // [RQ13]
            irq_ff          <= |(ev_f & irq_mask_ff);
        end
    end

    AST_AUTO_FILL: assert property (@(posedge sys_clk) disable iff (rst)
        fill_st_ff == TIF_F_WAIT && !wr_stat && sync_detect && in_buf
        |=> fill_bit) // [RQ1]
        else $error("sync did not start fill");
    AST_REARM: assert property (@(posedge sys_clk) disable iff (rst)
        fill_bit && !fill_method_ff && w_fill && !w_method && !ovr_f
        |=> fill_st_ff == TIF_F_WAIT) // [RQ4]
        else $error("fill not rearmed");
    AST_MANUAL: assert property (@(posedge sys_clk) disable iff (rst)
        wr_stat && wd[TIF_B_FILL_METHOD]
        |=> fill_bit == $past(wd[TIF_B_FILL])) // [RQ5]
        else $error("manual fill ignored");
    AST_PIN: assert property (@(posedge sys_clk) disable iff (rst)
        !lock_en_ff |=> !lock_pin_ff) // [RQ13]
        else $error("lock pin driven while disabled");
    AST_SIGLVL: assert property (@(posedge sys_clk) disable iff (rst)
        signal_level > thr_ff |=> siglvl_f) // [RQ11]
        else $error("signal level flag missed");
    AST_FLUSH: assert property (@(posedge sys_clk) disable iff (rst)
        ovr_clr && !overrun_event |=> fifo_flush_ff && !ovr_f) // [RQ16]
        else $error("overrun clear failed");
    COV_AUTO: cover property (@(posedge sys_clk)
        fill_st_ff == TIF_F_WAIT ##1 fill_bit);
    COV_IRQ: cover property (@(posedge sys_clk) irq_ff);
    COV_ERR: cover property (@(posedge sys_clk) wb_err_o);
endmodule // tif_top

// file: tif_fifo_model.sv
/*
 * FIFO occupancy model of the radio data path beside the block.
 * Assumes push and flush are one-clock pulses synchronous to sys_clk.
 */
`timescale 1ns/1ps
module tif_fifo_model
#(
    parameter int DEPTH = 4,
    parameter int THR   = 2
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic push,
    input  wire logic flush,
    output logic      fifo_full,
    output logic      fifo_not_empty,
    output logic      fill_level_hit
);
    int count_ff;
    always_ff @(posedge sys_clk)
    begin
        if (rst || flush)
            count_ff <= 0;
        else if (push && count_ff < DEPTH)
            count_ff <= count_ff + 1;
    end
    assign fifo_full      = (count_ff == DEPTH);
    assign fifo_not_empty = (count_ff != 0);
    assign fill_level_hit = (count_ff >= THR);
endmodule // tif_fifo_model

// file: tif_top_tb_top.sv
/*
 * Self-checking bench: Wishbone register calls, event pulses, FIFO model.
 * Assumes the DUT acks one cycle after a request is taken.
 */
`timescale 1ns/1ps
module tif_top_tb_top
    import tif_pkg::*;
;
    logic        sys_clk, rst, cyc, stb, we, push, synth_locked, flush_seen;
    logic [31:0] adr, dat, wb_dat_o;
    logic [3:0]  sel;
    logic [1:0]  data_mode;
    logic [2:0]  ev;
    logic [7:0]  signal_level, r;
    logic        wb_ack_o, wb_err_o, fifo_fill_en_ff, fifo_flush_ff, e;
    logic        tx_start_ff, irq0_ff, lock_pin_ff, irq_ff;
    logic        fifo_full, fifo_not_empty, fill_level_hit;
    int          n_fail, n_checks, cyc_cnt;

    tif_top dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .data_mode(data_mode), .sync_detect(ev[0]),
        .overrun_event(ev[1]), .tx_last_bit_out(ev[2]),
        .signal_level(signal_level), .synth_locked(synth_locked),
        .fifo_full(fifo_full), .fifo_not_empty(fifo_not_empty),
        .fill_level_hit(fill_level_hit), .fifo_fill_en_ff(fifo_fill_en_ff),
        .fifo_flush_ff(fifo_flush_ff), .tx_start_ff(tx_start_ff),
        .irq0_ff(irq0_ff), .lock_pin_ff(lock_pin_ff), .irq_ff(irq_ff));

    tif_fifo_model #(.DEPTH(4), .THR(2)) fifo (.sys_clk(sys_clk),
        .rst(rst), .push(push), .flush(fifo_flush_ff),
        .fifo_full(fifo_full), .fifo_not_empty(fifo_not_empty),
        .fill_level_hit(fill_level_hit));

    initial
    begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cyc_cnt++;
        if (fifo_flush_ff === 1'b1)
            flush_seen <= 1;
        if (cyc_cnt == 5000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; holds the request until ack or err is sampled
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge sys_clk);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= {22'h0, idx, 2'h0};
        dat <= {24'h0, wd};
        sel <= 4'hf;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        if (n == 50)
            n_fail++;
        r = wb_dat_o[7:0];
        e = wb_err_o;
        cyc <= 0;
        stb <= 0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(r, exp);
    endtask

    task pulse(input int i);
        @(posedge sys_clk);
        ev[i] <= 1;
        @(posedge sys_clk);
        ev <= 3'h0;
    endtask

    task hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    function automatic logic [1:0] exp_start(input logic [1:0] m,
                                             input logic s, input int c);
        logic f, ne, h;
        f  = (c == 4);
        ne = (c != 0);
        h  = (c >= 2);
        if (m == 2'h1)
            return s ? {ne, ne} : {f, ne};
        if (m[1])
            return s ? {ne, ne} : {h, h};
        return 2'h0;
    endfunction

    initial
    begin
        rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; sel = 0;
        push = 0; synth_locked = 0; signal_level = 0; data_mode = 0;
        ev = 0; flush_seen = 0; n_fail = 0; n_checks = 0; cyc_cnt = 0;
        hold(20);
        rst <= 0;
        rd_chk(TIF_IDX_STAT, 8'h01);
        rd_chk(TIF_IDX_THR, 8'h00);
        rd_chk(TIF_IDX_IRQMSK, 8'h00);
        synth_locked <= 1;
        hold(3);
        chk(lock_pin_ff, 1'b1);
        rd_chk(TIF_IDX_STAT, 8'h03);
        wr(TIF_IDX_STAT, 8'h08);
        hold(2);
        chk(lock_pin_ff, 1'b0);
        synth_locked <= 0;
        wr(TIF_IDX_STAT, 8'h0b);
        rd_chk(TIF_IDX_STAT, 8'h09);
        wr(TIF_IDX_THR, 8'h80);
        rd_chk(TIF_IDX_THR, 8'h80);
        signal_level <= 8'h80;
        hold(3);
        rd_chk(TIF_IDX_STAT, 8'h09);
        signal_level <= 8'h81;
        hold(3);
        rd_chk(TIF_IDX_LEVEL, 8'h81);
        signal_level <= 8'h00;
        hold(3);
        rd_chk(TIF_IDX_STAT, 8'h0d);
        wr(TIF_IDX_IRQMSK, 8'h02);
        hold(2);
        chk(irq_ff, 1'b1);
        wr(TIF_IDX_IRQMSK, 8'h00);
        hold(2);
        chk(irq_ff, 1'b0);
        wr(TIF_IDX_IRQMSK, 8'h02);
        wr(TIF_IDX_IRQST, 8'h02);
        hold(2);
        chk(irq_ff, 1'b0);
        wr(TIF_IDX_STAT, 8'h0d);
        rd_chk(TIF_IDX_STAT, 8'h09);
        bus(1'b0, 8'h10, 8'h00);
        chk(e, 1'b1);
        pulse(2);
        hold(2);
        rd_chk(TIF_IDX_STAT, 8'h29);
        wr(TIF_IDX_STAT, 8'h09);
        rd_chk(TIF_IDX_STAT, 8'h29);
        data_mode <= TIF_MODE_BUF;
        pulse(0);
        hold(2);
        chk(fifo_fill_en_ff, 1'b1);
        rd_chk(TIF_IDX_STAT, 8'h69);
        wr(TIF_IDX_STAT, 8'h69);
        hold(2);
        chk(fifo_fill_en_ff, 1'b0);
        rd_chk(TIF_IDX_STAT, 8'h29);
        pulse(0);
        hold(2);
        chk(fifo_fill_en_ff, 1'b1);
        wr(TIF_IDX_STAT, 8'h89);
        hold(2);
        chk(fifo_fill_en_ff, 1'b0);
        pulse(0);
        hold(2);
        chk(fifo_fill_en_ff, 1'b0);
        wr(TIF_IDX_STAT, 8'hc9);
        hold(2);
        chk(fifo_fill_en_ff, 1'b1);
        for (int c = 0; c <= 4; c++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                @(posedge sys_clk);
                data_mode <= k[2:1];
                wr(TIF_IDX_STAT, {3'h0, k[0], 4'h9});
                hold(3);
                chk({tx_start_ff, irq0_ff}, exp_start(k[2:1], k[0], c));
            end
            @(posedge sys_clk);
            push <= 1;
            @(posedge sys_clk);
            push <= 0;
        end
        rd_chk(TIF_IDX_CTRL, 8'h03);
        pulse(1);
        hold(2);
        rd_chk(TIF_IDX_OVR, 8'h01);
        flush_seen <= 0;
        wr(TIF_IDX_OVR, 8'h01);
        hold(3);
        chk(flush_seen, 1'b1);
        chk(fifo_not_empty, 1'b0);
        rd_chk(TIF_IDX_OVR, 8'h00);
        rd_chk(TIF_IDX_IRQST, 8'h0d);
        complete_run();
    end
endmodule // tif_top_tb_top
